// ===== rtl/pwrseq_pkg.sv
// Constants for the power-up sequencer: command codes, reset values,
// response field layout and timing.
// Assumes one 50 MHz clock and a millisecond time base derived from it.
package pwrseq_pkg;

  // Command codes of the management registers
  localparam logic [7:0] CMD_OK_RISE_THR = 8'h5E;
  localparam logic [7:0] CMD_OK_FALL_THR = 8'h5F;
  localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RAMP = 8'h61;
  localparam logic [7:0] CMD_PU_TIME_LIMIT = 8'h62;
  localparam logic [7:0] CMD_PU_TIMEOUT_RESP = 8'h63;

  // Reset values
  localparam logic [15:0] RST_OK_RISE_THR = 16'h0000;
  localparam logic [15:0] RST_OK_FALL_THR = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_DELAY = 16'h0000;
  localparam logic [15:0] RST_TURN_ON_RAMP = 16'h0000;
  localparam logic [15:0] RST_PU_TIME_LIMIT = 16'h0000;
  localparam logic [7:0] RST_PU_TIMEOUT_RESP = 8'h00;

  // Response register fields
  localparam int RESP_CODE_MSB = 7;
  localparam int RESP_CODE_LSB = 6;
  localparam int RESP_RETRY_MSB = 5;
  localparam int RESP_RETRY_LSB = 3;
  localparam int RESP_DELAY_MSB = 2;
  localparam int RESP_DELAY_LSB = 0;

  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_CONTINUE = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH_OFF = 2'h3;

  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 24;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_DELAY = 3'b001,
    ST_RISE = 3'b010,
    ST_ON = 3'b011,
    ST_CONTINUE = 3'b100,
    ST_RETRY_WAIT = 3'b101,
    ST_LATCHED = 3'b110
  } seq_state_t;

endpackage : pwrseq_pkg

// ===== rtl/ms_tick_gen.sv
// Millisecond enable divider for the sequencer.
// Assumes a free-running clock; tick is a one-cycle pulse each period.
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
  parameter int DIVIDE = pwrseq_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  localparam int CW = $clog2(DIVIDE + 1);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + CW'(1);
    if (cnt_q == LAST) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : ms_tick_gen
`default_nettype wire

// ===== rtl/power_up_sequencer.sv
// Turn-on sequencing, output-ok supervision and power-up timeout response.
// Assumes the management link decoder delivers one-cycle command strobes
// on MCLK; the control pin and output sense come from outside and are
// synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Output-ok asserts when output reaches the 16-bit rise threshold.
// - Output-ok negates below fall threshold when enabled by multi-pin setting.
// - Falling below fall threshold sets the output-ok status flag to one.
// - After enable, wait the millisecond turn-on delay before raising output.
// - After the delay, ramp the output over the millisecond rise time.
// - Timeout fault if undervoltage limit not reached within power-up limit.
// - A power-up time limit of zero disables the timeout.
// - Timeout response is an 8-bit setting; all four codes are supported.
// - Response 00 ignores the timeout and keeps operating.
// - Response 01 keeps operating for the delay, then follows retry count if fault persists.
// - Response 10 disables the output at once, then follows retry count.
// - Response 11 latches off until fault clear, clear-all or reset.
// - Commanding the output off then on also clears a latched fault.
// - Retry count 000 keeps the output off until the fault is cleared.
// - Retry counts one to four restart that often, then stay off.
// - Restart spacing equals two to the delay field value times the fault's time unit.
// - Retry counts five and six restart that often, then stay off.
// - Retry count 111 restarts without limit until commanded off.
// - Delay field value n gives two to the n time units.
module power_up_sequencer #(
  parameter int CYCLES_PER_MS = pwrseq_pkg::CYCLES_PER_MS
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  output logic [15:0] CMD_RDATA,
  output logic CMD_ACK,
  output logic CMD_NACK,
  input wire logic CTRL_PIN,
  input wire logic OPERATION_ON,
  input wire logic OK_PIN_ENABLE,
  input wire logic [15:0] VOUT_SENSE,
  input wire logic [15:0] UV_FAULT_LIMIT,
  input wire logic [15:0] FAULT_TIME_UNIT_MS,
  input wire logic CLEAR_FAULTS,
  input wire logic CLEAR_TIMEOUT_FAULT,
  output logic OUTPUT_OK,
  output logic OUTPUT_OK_STATUS,
  output logic TIMEOUT_FAULT,
  output logic OUTPUT_ENABLE,
  output logic RAMP_ACTIVE,
  output logic LATCHED_OFF
);

  localparam int W = pwrseq_pkg::MS_CNT_W;

  // Two-stage synchronisers for outside signals
  logic [16:0] sync1_q;
  logic [16:0] sync2_q;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {CTRL_PIN, VOUT_SENSE};
      sync2_q <= sync1_q;
    end
  end
  logic ctrl_s;
  logic [15:0] vout_s;
  assign ctrl_s = sync2_q[16];
  assign vout_s = sync2_q[15:0];

  logic ms_tick;
  ms_tick_gen #(
    .DIVIDE(CYCLES_PER_MS)
  ) u_ms_tick (
    .clk(MCLK),
    .rst_n(RESETN),
    .tick(ms_tick)
  );

  // Management registers
  logic [15:0] ok_rise_thr_q, ok_rise_thr_d;
  logic [15:0] ok_fall_thr_q, ok_fall_thr_d;
  logic [15:0] on_delay_q, on_delay_d;
  logic [15:0] on_ramp_q, on_ramp_d;
  logic [15:0] pu_limit_q, pu_limit_d;
  logic [7:0] pu_resp_q, pu_resp_d;
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic nack_q, nack_d;

  always_comb begin
    ok_rise_thr_d = ok_rise_thr_q;
    ok_fall_thr_d = ok_fall_thr_q;
    on_delay_d = on_delay_q;
    on_ramp_d = on_ramp_q;
    pu_limit_d = pu_limit_q;
    pu_resp_d = pu_resp_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    nack_d = 1'b0;
    if (CMD_WR || CMD_RD) begin
      ack_d = 1'b1;
      if (CMD_CODE == pwrseq_pkg::CMD_OK_RISE_THR) begin
        if (CMD_WR) ok_rise_thr_d = CMD_WDATA;
        rdata_d = ok_rise_thr_q;
      end else if (CMD_CODE == pwrseq_pkg::CMD_OK_FALL_THR) begin
        if (CMD_WR) ok_fall_thr_d = CMD_WDATA;
        rdata_d = ok_fall_thr_q;
      end else if (CMD_CODE == pwrseq_pkg::CMD_TURN_ON_DELAY) begin
        if (CMD_WR) on_delay_d = CMD_WDATA;
        rdata_d = on_delay_q;
      end else if (CMD_CODE == pwrseq_pkg::CMD_TURN_ON_RAMP) begin
        if (CMD_WR) on_ramp_d = CMD_WDATA;
        rdata_d = on_ramp_q;
      end else if (CMD_CODE == pwrseq_pkg::CMD_PU_TIME_LIMIT) begin
        if (CMD_WR) pu_limit_d = CMD_WDATA;
        rdata_d = pu_limit_q;
      end else if (CMD_CODE == pwrseq_pkg::CMD_PU_TIMEOUT_RESP) begin
        if (CMD_WR) pu_resp_d = CMD_WDATA[7:0];
        rdata_d = {8'h00, pu_resp_q};
      end else begin
        ack_d = 1'b0;
        nack_d = 1'b1;
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ok_rise_thr_q <= pwrseq_pkg::RST_OK_RISE_THR;
      ok_fall_thr_q <= pwrseq_pkg::RST_OK_FALL_THR;
      on_delay_q <= pwrseq_pkg::RST_TURN_ON_DELAY;
      on_ramp_q <= pwrseq_pkg::RST_TURN_ON_RAMP;
      pu_limit_q <= pwrseq_pkg::RST_PU_TIME_LIMIT;
      pu_resp_q <= pwrseq_pkg::RST_PU_TIMEOUT_RESP;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      ok_rise_thr_q <= ok_rise_thr_d;
      ok_fall_thr_q <= ok_fall_thr_d;
      on_delay_q <= on_delay_d;
      on_ramp_q <= on_ramp_d;
      pu_limit_q <= pu_limit_d;
      pu_resp_q <= pu_resp_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      nack_q <= nack_d;
    end
  end

  // Sequencer state
  pwrseq_pkg::seq_state_t state_q, state_d;
  logic [W-1:0] seq_ms_q, seq_ms_d;
  logic [W-1:0] pu_ms_q, pu_ms_d;
  logic reached_q, reached_d;
  logic in_seq_q, in_seq_d;
  logic [7:0] act_resp_q, act_resp_d;
  logic [2:0] retries_left_q, retries_left_d;
  logic fault_q, fault_d;
  logic out_en_q, out_en_d;

  logic enabled;
  logic fault_clear;
  logic timeout_evt;
  logic [7:0] eff_resp;
  logic [2:0] eff_retry;
  logic [W-1:0] wait_ms;
  logic powered;

  assign enabled = ctrl_s & OPERATION_ON;
  assign fault_clear = CLEAR_FAULTS | CLEAR_TIMEOUT_FAULT;
  // Running sequence keeps the response captured at its first fault
  assign eff_resp = in_seq_q ? act_resp_q : pu_resp_q;
  assign eff_retry = in_seq_q ? retries_left_q
                              : pu_resp_q[pwrseq_pkg::RESP_RETRY_MSB:pwrseq_pkg::RESP_RETRY_LSB];
  assign wait_ms = {8'h00, FAULT_TIME_UNIT_MS}
                   << eff_resp[pwrseq_pkg::RESP_DELAY_MSB:pwrseq_pkg::RESP_DELAY_LSB];
  assign powered = (state_q == pwrseq_pkg::ST_RISE) || (state_q == pwrseq_pkg::ST_ON)
                   || (state_q == pwrseq_pkg::ST_CONTINUE);
  assign timeout_evt = ms_tick && (pu_limit_q != 16'h0000) && !reached_q
                       && (pu_ms_q >= {8'h00, pu_limit_q})
                       && ((state_q == pwrseq_pkg::ST_DELAY) || (state_q == pwrseq_pkg::ST_RISE)
                           || (state_q == pwrseq_pkg::ST_ON));

  always_comb begin
    state_d = state_q;
    pu_ms_d = pu_ms_q;
    reached_d = reached_q;
    in_seq_d = in_seq_q;
    act_resp_d = act_resp_q;
    retries_left_d = retries_left_q;
    if (powered && vout_s >= UV_FAULT_LIMIT) reached_d = 1'b1;
    if (ms_tick && !reached_q && pu_ms_q != {W{1'b1}}) pu_ms_d = pu_ms_q + W'(1);
    case (state_q)
      pwrseq_pkg::ST_OFF: begin
        in_seq_d = 1'b0;
        if (enabled) begin
          state_d = pwrseq_pkg::ST_DELAY;
          pu_ms_d = '0;
          reached_d = 1'b0;
        end
      end
      pwrseq_pkg::ST_DELAY: begin
        if (seq_ms_q >= {8'h00, on_delay_q}) state_d = pwrseq_pkg::ST_RISE;
      end
      pwrseq_pkg::ST_RISE: begin
        if (seq_ms_q >= {8'h00, on_ramp_q}) state_d = pwrseq_pkg::ST_ON;
      end
      pwrseq_pkg::ST_ON: begin
        if (reached_q) in_seq_d = 1'b0;
      end
      pwrseq_pkg::ST_CONTINUE: begin
        if (reached_q) begin
          state_d = pwrseq_pkg::ST_ON;
          in_seq_d = 1'b0;
        end else if (seq_ms_q >= wait_ms) begin
          state_d = pwrseq_pkg::ST_RETRY_WAIT;
          if (retries_left_q == pwrseq_pkg::RETRY_NONE) begin
            state_d = pwrseq_pkg::ST_LATCHED;
          end else if (retries_left_q != pwrseq_pkg::RETRY_FOREVER) begin
            retries_left_d = retries_left_q - 3'h1;
          end
        end
      end
      pwrseq_pkg::ST_RETRY_WAIT: begin
        if (seq_ms_q >= wait_ms) begin
          state_d = pwrseq_pkg::ST_DELAY;
          pu_ms_d = '0;
          reached_d = 1'b0;
        end
      end
      pwrseq_pkg::ST_LATCHED: begin
        if (fault_clear) state_d = pwrseq_pkg::ST_OFF;
      end
      default: state_d = pwrseq_pkg::ST_OFF;
    endcase
    if (timeout_evt) begin
      in_seq_d = 1'b1;
      act_resp_d = eff_resp;
      retries_left_d = eff_retry;
      case (eff_resp[pwrseq_pkg::RESP_CODE_MSB:pwrseq_pkg::RESP_CODE_LSB])
        pwrseq_pkg::RESP_IGNORE: begin
          reached_d = 1'b1;
          in_seq_d = in_seq_q;
        end
        pwrseq_pkg::RESP_CONTINUE: state_d = pwrseq_pkg::ST_CONTINUE;
        pwrseq_pkg::RESP_DISABLE_RETRY: begin
          state_d = pwrseq_pkg::ST_RETRY_WAIT;
          if (eff_retry == pwrseq_pkg::RETRY_NONE) begin
            state_d = pwrseq_pkg::ST_LATCHED;
          end else if (eff_retry != pwrseq_pkg::RETRY_FOREVER) begin
            retries_left_d = eff_retry - 3'h1;
          end
        end
        default: state_d = pwrseq_pkg::ST_LATCHED;
      endcase
    end
    // Off command wins over every state, latched included
    if (!enabled) begin
      state_d = pwrseq_pkg::ST_OFF;
      in_seq_d = 1'b0;
    end
  end

  always_comb begin
    seq_ms_d = seq_ms_q;
    if (state_d != state_q) begin
      seq_ms_d = '0;
    end else if (ms_tick && seq_ms_q != {W{1'b1}}) begin
      seq_ms_d = seq_ms_q + W'(1);
    end
    // Set wins over clear
    fault_d = fault_q;
    if (fault_clear) fault_d = 1'b0;
    if (timeout_evt) fault_d = 1'b1;
    out_en_d = (state_d == pwrseq_pkg::ST_RISE) || (state_d == pwrseq_pkg::ST_ON)
               || (state_d == pwrseq_pkg::ST_CONTINUE);
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= pwrseq_pkg::ST_OFF;
      seq_ms_q <= '0;
      pu_ms_q <= '0;
      reached_q <= 1'b0;
      in_seq_q <= 1'b0;
      act_resp_q <= 8'h00;
      retries_left_q <= 3'h0;
      fault_q <= 1'b0;
      out_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      seq_ms_q <= seq_ms_d;
      pu_ms_q <= pu_ms_d;
      reached_q <= reached_d;
      in_seq_q <= in_seq_d;
      act_resp_q <= act_resp_d;
      retries_left_q <= retries_left_d;
      fault_q <= fault_d;
      out_en_q <= out_en_d;
    end
  end

  // Output-ok supervision
  logic good_q, good_d;
  logic low_flag_q, low_flag_d;
  logic ok_pin_q, ok_pin_d;
  logic ramp_q, ramp_d;
  logic latched_q, latched_d;

  always_comb begin
    good_d = good_q;
    low_flag_d = low_flag_q;
    if (!powered) begin
      good_d = 1'b0;
    end else if (vout_s >= ok_rise_thr_q) begin
      good_d = 1'b1;
      low_flag_d = 1'b0;
    end
    if (good_q && vout_s < ok_fall_thr_q) begin
      good_d = 1'b0;
      low_flag_d = 1'b1;
    end
    // Pin stays low when not routed by the multi-pin setting
    ok_pin_d = good_d & OK_PIN_ENABLE;
    ramp_d = (state_d == pwrseq_pkg::ST_RISE);
    latched_d = (state_d == pwrseq_pkg::ST_LATCHED);
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      good_q <= 1'b0;
      low_flag_q <= 1'b0;
      ok_pin_q <= 1'b0;
      ramp_q <= 1'b0;
      latched_q <= 1'b0;
    end else begin
      good_q <= good_d;
      low_flag_q <= low_flag_d;
      ok_pin_q <= ok_pin_d;
      ramp_q <= ramp_d;
      latched_q <= latched_d;
    end
  end

  assign CMD_RDATA = rdata_q;
  assign CMD_ACK = ack_q;
  assign CMD_NACK = nack_q;
  assign OUTPUT_OK = ok_pin_q;
  assign OUTPUT_OK_STATUS = low_flag_q;
  assign TIMEOUT_FAULT = fault_q;
  assign OUTPUT_ENABLE = out_en_q;
  assign RAMP_ACTIVE = ramp_q;
  assign LATCHED_OFF = latched_q;

endmodule : power_up_sequencer
`default_nettype wire

// ===== sim/pwrseq_asserts.sv
// Port checker for the power-up sequencer.
// Bound to power_up_sequencer from the bench top file; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module pwrseq_asserts (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_RDATA,
  input wire logic CMD_ACK,
  input wire logic CMD_NACK,
  input wire logic CTRL_PIN,
  input wire logic OPERATION_ON,
  input wire logic OK_PIN_ENABLE,
  input wire logic OUTPUT_OK,
  input wire logic OUTPUT_ENABLE,
  input wire logic RAMP_ACTIVE,
  input wire logic LATCHED_OFF
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  logic strobe;
  logic mapped;
  assign strobe = CMD_WR | CMD_RD;
  assign mapped = (CMD_CODE >= pwrseq_pkg::CMD_OK_RISE_THR)
                  && (CMD_CODE <= pwrseq_pkg::CMD_PU_TIMEOUT_RESP);
  chk_ack_mapped: assert property (strobe && mapped |=> CMD_ACK && !CMD_NACK)
    else $error("mapped access not acknowledged");
  chk_nack_unmapped: assert property (strobe && !mapped |=> CMD_NACK && !CMD_ACK)
    else $error("unmapped access not refused");
  chk_no_stray_answer: assert property (!strobe |=> !CMD_ACK && !CMD_NACK)
    else $error("answer without request");
  chk_rdata_holds: assert property (!strobe |=> $stable(CMD_RDATA))
    else $error("read data moved without request");
  chk_ramp_powered: assert property (RAMP_ACTIVE |-> OUTPUT_ENABLE)
    else $error("ramp with power stage off");
  chk_latch_is_off: assert property (LATCHED_OFF |-> !OUTPUT_ENABLE)
    else $error("output on while latched off");
  chk_pin_off_stops: assert property (!CTRL_PIN [*4] |-> !OUTPUT_ENABLE)
    else $error("output on after control pin off");
  chk_op_off_stops: assert property (!OPERATION_ON [*3] |-> !OUTPUT_ENABLE)
    else $error("output on after operation off");
  chk_ok_pin_gate: assert property (!OK_PIN_ENABLE [*2] |-> !OUTPUT_OK)
    else $error("output-ok high while pin disabled");
endmodule : pwrseq_asserts
`default_nettype wire

// ===== sim/host_model.sv
// Management host model: one command strobe per transfer.
// Assumes the bench clock; drives on falling edges, samples the answer one cycle on.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_nack
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Word and byte transfers; byte data rides in bits 7:0
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rdata, output logic [1:0] resp);
    @(negedge mclk);
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge mclk);
    rdata = cmd_rdata;
    resp = {cmd_ack, cmd_nack};
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    // Released lines show junk, not the last value
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the power-up sequencer.
// Assumes host_model and pwrseq_asserts; output voltage is driven directly.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int MS = 20;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic wr, rd, ack, nack, ctrl, op, ok_en, clr_all, clr_one;
  logic ok, ok_stat, fault, en, ramp, latched;
  logic [7:0] code;
  logic [15:0] wdata, rdata, vout, uv, unit;
  logic [4:0] obs;
  int n_mismatch = 0;
  int checked = 0;
  assign obs = {ok, fault, latched, ramp, en};
  always #10 mclk = ~mclk;
  host_model host_u (.mclk(mclk), .cmd_wr(wr), .cmd_rd(rd), .cmd_code(code),
    .cmd_wdata(wdata), .cmd_rdata(rdata), .cmd_ack(ack), .cmd_nack(nack));
  power_up_sequencer #(.CYCLES_PER_MS(MS)) dut_u (.MCLK(mclk), .RESETN(resetn),
    .CMD_WR(wr), .CMD_RD(rd), .CMD_CODE(code), .CMD_WDATA(wdata), .CMD_RDATA(rdata),
    .CMD_ACK(ack), .CMD_NACK(nack), .CTRL_PIN(ctrl), .OPERATION_ON(op),
    .OK_PIN_ENABLE(ok_en), .VOUT_SENSE(vout), .UV_FAULT_LIMIT(uv),
    .FAULT_TIME_UNIT_MS(unit), .CLEAR_FAULTS(clr_all), .CLEAR_TIMEOUT_FAULT(clr_one),
    .OUTPUT_OK(ok), .OUTPUT_OK_STATUS(ok_stat), .TIMEOUT_FAULT(fault),
    .OUTPUT_ENABLE(en), .RAMP_ACTIVE(ramp), .LATCHED_OFF(latched));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic in_range(input int n, input int lo, input int hi, input string what);
    check(16'(n >= lo && n <= hi), 16'h0001, what);
  endtask : in_range
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // Bounded wait for one observed output to reach a level
  task automatic wait_sig(input int w, input logic lvl, output int n);
    n = 0;
    while (obs[w] !== lvl && n < 60 * MS) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_sig
  task automatic wreg(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic [1:0] resp;
    host_u.xfer(1'b1, c, d, r, resp);
    check(16'(resp), 16'h0002, "write answer");
  endtask : wreg
  task automatic cfg(input logic [15:0] dly, input logic [15:0] rise,
                     input logic [15:0] lim, input logic [7:0] resp);
    wreg(8'h5E, 16'h0800);
    wreg(8'h5F, 16'h0400);
    wreg(8'h60, dly);
    wreg(8'h61, rise);
    wreg(8'h62, lim);
    wreg(8'h63, {8'h00, resp});
  endtask : cfg
  task automatic shut();
    ctrl = 1'b0;
    cyc(6);
    clr_all = 1'b1;
    cyc(1);
    clr_all = 1'b0;
    cyc(4);
  endtask : shut
  task automatic t_regs();
    logic [15:0] r, e;
    logic [1:0] resp;
    for (int i = 0; i < 6; i++) begin
      host_u.xfer(1'b0, 8'h5E + 8'(i), 16'h0000, r, resp);
      check(r, 16'h0000, "reset value");
      wreg(8'h5E + 8'(i), 16'hA5C3 ^ 16'(i));
    end
    for (int i = 0; i < 6; i++) begin
      host_u.xfer(1'b0, 8'h5E + 8'(i), 16'h0000, r, resp);
      e = 16'hA5C3 ^ 16'(i);
      if (i == 5) e[15:8] = 8'h00;
      check(r, e, "readback");
    end
    host_u.xfer(1'b1, 8'h64, 16'h1234, r, resp);
    check(16'(resp), 16'h0001, "unmapped write");
    host_u.xfer(1'b0, 8'h5D, 16'h0000, r, resp);
    check(r, 16'h0000, "unmapped read");
    check(16'(resp), 16'h0001, "unmapped read answer");
    $display("test regs done");
  endtask : t_regs
  task automatic t_seq();
    int n;
    cfg(16'd3, 16'd2, 16'd0, 8'hC0);
    ctrl = 1'b1;
    wait_sig(1, 1'b1, n);
    in_range(n, 2 * MS, 3 * MS + 8, "turn-on delay");
    wait_sig(1, 1'b0, n);
    in_range(n, MS, 2 * MS + 4, "rise time");
    cyc(10 * MS);
    check(16'({fault, en}), 16'h0001, "no limit");
    vout = 16'h0900;
    wait_sig(4, 1'b1, n);
    in_range(n, 0, 8, "output-ok rise");
    vout = 16'h0300;
    cyc(8);
    check(16'({ok, ok_stat}), 16'h0001, "output-ok fall");
    vout = 16'h0900;
    ok_en = 1'b0;
    cyc(8);
    check(16'(ok), 16'h0000, "output-ok pin off");
    ok_en = 1'b1;
    vout = 16'h0000;
    shut();
    $display("test sequence done");
  endtask : t_seq
  task automatic t_latch();
    int n;
    cfg(16'd1, 16'd8, 16'd3, 8'hC0);
    ctrl = 1'b1;
    wait_sig(2, 1'b1, n);
    // Timeout fires on the first tick after the limit count is reached
    in_range(n, 3 * MS, 4 * MS + 8, "timeout moment");
    cyc(5 * MS);
    check(16'({fault, latched, en}), 16'h0006, "latched off");
    clr_one = 1'b1;
    cyc(1);
    clr_one = 1'b0;
    cyc(3);
    check(16'({fault, latched}), 16'h0000, "bit clear");
    wait_sig(2, 1'b1, n);
    check(16'(latched), 16'h0001, "latched again");
    op = 1'b0;
    cyc(3);
    check(16'({latched, en}), 16'h0000, "operation off");
    op = 1'b1;
    wait_sig(0, 1'b1, n);
    check(16'({latched, en}), 16'h0001, "back on");
    wait_sig(2, 1'b1, n);
    ctrl = 1'b0;
    cyc(6);
    check(16'(latched), 16'h0000, "off clears");
    shut();
    $display("test latch done");
  endtask : t_latch
  // Counts turn-ons, first included, until latched or a time span runs out
  task automatic run_retry(input logic [2:0] r, input int span, output int rises,
                           output int low);
    int t;
    logic prev;
    cfg(16'd0, 16'd4, 16'd2, {2'b10, r, 3'd1});
    ctrl = 1'b1;
    rises = 0;
    low = 0;
    prev = 1'b0;
    t = 0;
    while (latched !== 1'b1 && t < span) begin
      @(negedge mclk);
      t++;
      if (en === 1'b1 && prev !== 1'b1) rises++;
      if (en !== 1'b1 && rises > 0) low++;
      if (en === 1'b1) low = 0;
      if (t == 10 * MS && r == 3'd7) wreg(8'h63, 16'h00C0);
      prev = en;
    end
  endtask : run_retry
  task automatic t_retry();
    int rises, low;
    for (int r = 0; r < 7; r++) begin
      run_retry(3'(r), 40 * MS, rises, low);
      check(16'(rises), 16'(r + 1), "attempts");
      check(16'(latched), 16'h0001, "stays off");
      shut();
    end
    run_retry(3'd2, 40 * MS, rises, low);
    check(16'(rises), 16'h0003, "second run");
    shut();
    run_retry(3'd7, 30 * MS, rises, low);
    in_range(rises, 6, 10, "endless retries");
    check(16'(latched), 16'h0000, "never latches");
    shut();
    $display("test retry done");
  endtask : t_retry
  task automatic t_spacing();
    int rises, low;
    run_retry(3'd1, 40 * MS, rises, low);
    check(16'(rises), 16'h0002, "retry once");
    cyc(1);
    shut();
    cfg(16'd0, 16'd8, 16'd2, 8'h93);
    ctrl = 1'b1;
    wait_sig(0, 1'b1, low);
    wait_sig(0, 1'b0, low);
    wait_sig(0, 1'b1, low);
    in_range(low, 7 * MS, 8 * MS + 6, "restart spacing");
    shut();
    $display("test spacing done");
  endtask : t_spacing
  task automatic t_soft();
    int n;
    cfg(16'd0, 16'd1, 16'd2, 8'h00);
    ctrl = 1'b1;
    wait_sig(3, 1'b1, n);
    cyc(10 * MS);
    check(16'({fault, latched, en}), 16'h0005, "ignore");
    shut();
    cfg(16'd0, 16'd1, 16'd2, 8'h41);
    ctrl = 1'b1;
    wait_sig(3, 1'b1, n);
    wait_sig(0, 1'b0, n);
    in_range(n, MS, 2 * MS + 6, "continue span");
    cyc(4);
    check(16'(latched), 16'h0001, "continue then off");
    shut();
    cfg(16'd0, 16'd1, 16'd2, 8'h49);
    ctrl = 1'b1;
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    in_range(n, MS, 2 * MS + 6, "continue retry wait");
    wait_sig(2, 1'b1, n);
    check(16'({latched, en}), 16'h0002, "continue retries spent");
    shut();
    $display("test soft done");
  endtask : t_soft
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    {ctrl, ok_en, clr_all, clr_one} = 4'h0;
    op = 1'b1;
    vout = 16'h0000;
    uv = 16'h0100;
    unit = 16'h0001;
    cyc(16);
    resetn = 1'b1;
    t_regs();
    ok_en = 1'b1;
    t_seq();
    t_latch();
    t_retry();
    t_spacing();
    t_soft();
    op = 1'b0;
    cyc(4);
    print_verdict();
  end
  initial begin
    // About four times the expected length of all scenarios
    #400us;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top
bind power_up_sequencer pwrseq_asserts chk_u (.MCLK, .RESETN, .CMD_WR, .CMD_RD,
  .CMD_CODE, .CMD_RDATA, .CMD_ACK, .CMD_NACK, .CTRL_PIN, .OPERATION_ON,
  .OK_PIN_ENABLE, .OUTPUT_OK, .OUTPUT_ENABLE, .RAMP_ACTIVE, .LATCHED_OFF);
`default_nettype wire
